// >>> rtl/spsf_pkg.sv
// spsf_pkg: register map, field layouts, reset values and timing of the
// serial port status block.
// assumes a 100 MHz mclk and a 32-bit APB register bus.
package spsf_pkg;
   localparam logic [7:0] ADDR_STATUS   = 8'h00;
   localparam logic [7:0] ADDR_CTRL     = 8'h04;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
   localparam logic [7:0] ADDR_DATA     = 8'h10;

   localparam logic [7:0] STATUS_RST    = 8'h00;
   localparam logic [7:0] CTRL_RST      = 8'h00;
   localparam logic [2:0] IRQ_RST       = 3'h0;
   localparam logic [7:0] DATA_RST      = 8'h00;

   localparam int IRQ_START  = 0;
   localparam int IRQ_STOP   = 1;
   localparam int IRQ_BYTE   = 2;
   localparam int IRQ_W      = 3;

   localparam int CLK_PERIOD_NS = 10;
   localparam int SCK_PERIOD_NS = 80;
   // longest half period, rounded down, never below one cycle
   localparam int SCK_HALF_CYC  = (SCK_PERIOD_NS / (2 * CLK_PERIOD_NS)) < 1 ? 1 :
                                  (SCK_PERIOD_NS / (2 * CLK_PERIOD_NS));
   localparam logic [4:0] SPI_TOGGLES = 5'h10;
   localparam logic [3:0] SPI_BITS    = 4'h8;
   localparam logic [3:0] I2C_BITS    = 4'h9;

   typedef enum logic [1:0] {
      SPSF_MODE_SPI_MASTER = 2'b00,
      SPSF_MODE_SPI_SLAVE  = 2'b01,
      SPSF_MODE_I2C        = 2'b10,
      SPSF_MODE_RSVD       = 2'b11
   } spsf_mode_type;

   typedef struct packed {
      logic       sample_phase_select;
      logic       edge_select;
      logic       data_addr;
      logic       stop_seen;
      logic       start_seen;
      logic [2:0] low_bits;
   } spsf_status_type;

   typedef struct packed {
      logic [3:0]    rsvd;
      logic          clk_idle_high;
      spsf_mode_type mode;
      logic          port_enable_bit;
   } spsf_ctrl_type;
endpackage : spsf_pkg

// >>> rtl/spsf_sync.sv
// spsf_sync: two-flop synchroniser for pin inputs.
// assumes inputs are asynchronous to mclk; only the second stage is read.
`timescale 1ns/10ps
module spsf_sync #(
   parameter int WIDTH = 2
) (
   input  wire logic             mclk,
   input  wire logic             nrst,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_q;

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         meta_q   <= '0;
         sync_out <= '0;
      end else begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule : spsf_sync

// >>> rtl/spsf_top.sv
// spsf_top: status flags, SPI shifter and I2C bus watcher of a serial port.
// assumes APB master on mclk; sck_in and sd_in are raw pins (scl/sda in I2C).
//
// Functional notes
// - SPI: edge bit 1 shifts on active-to-idle, 0 on idle-to-active.
// - I2C: edge bit 1 enables SMBus input thresholds, 0 disables them.
// - I2C: data-or-address flag 1 after data byte, 0 after address byte.
// - I2C: stop-seen set when stop was last condition; zero at reset.
// - I2C: start-seen set when start was last condition; zero at reset.
// - disabling the port clears start-seen and stop-seen.
//
// Chosen here: the APB register port and the register addresses.
`timescale 1ns/10ps
module spsf_top #(
   parameter int SCK_HALF = spsf_pkg::SCK_HALF_CYC
) (
   input  wire logic        mclk,
   input  wire logic        nrst,
   input  wire logic [7:0]  paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        sck_in,
   input  wire logic        sd_in,
   output logic             sck_out,
   output logic             sck_oe,
   output logic             sdo_out,
   output logic             sdo_oe,
   output logic             smbus_thresh_en,
   output logic             irq
);
   spsf_pkg::spsf_status_type stat_q, stat_d;
   spsf_pkg::spsf_ctrl_type   ctrl_q, ctrl_d;
   logic [spsf_pkg::IRQ_W-1:0] ist_q, ist_d, imask_q, imask_d, ievt;
   logic [7:0]  rx_q, rx_d, rxsh_q, rxsh_d, txsh_q, txsh_d;
   logic [3:0]  bits_q, bits_d;
   logic [4:0]  tog_q, tog_d;
   logic [7:0]  div_q, div_d, dly_q, dly_d;
   logic        run_q, run_d, sckl_q, sckl_d, addr_pend_q, addr_pend_d;
   logic        sck_prev_q, sd_prev_q;
   logic [31:0] prdata_d;
   logic        pready_d, pslverr_d, sdo_d, irq_d;
   logic [1:0]  pins_s;
   logic        sck_s, sd_s, acc, wr_en, en, spi, i2c, master;
   logic        edge_evt, lead_evt, trail_evt, shift_evt, samp_evt, do_samp;
   logic        start_evt, stop_evt;

   spsf_sync #(.WIDTH(2)) u_sync (
      .mclk     (mclk),
      .nrst     (nrst),
      .async_in ({sck_in, sd_in}),
      .sync_out (pins_s)
   );
   assign sck_s = pins_s[1];
   assign sd_s  = pins_s[0];

   function automatic logic mapped(input logic [7:0] a);
      mapped = (a == spsf_pkg::ADDR_STATUS) || (a == spsf_pkg::ADDR_CTRL) ||
               (a == spsf_pkg::ADDR_IRQ_STAT) || (a == spsf_pkg::ADDR_IRQ_MASK) ||
               (a == spsf_pkg::ADDR_DATA);
   endfunction : mapped

   always_comb begin
      en     = ctrl_q.port_enable_bit;
      spi    = en && (ctrl_q.mode == spsf_pkg::SPSF_MODE_SPI_MASTER ||
                      ctrl_q.mode == spsf_pkg::SPSF_MODE_SPI_SLAVE);
      master = en && (ctrl_q.mode == spsf_pkg::SPSF_MODE_SPI_MASTER);
      i2c    = en && (ctrl_q.mode == spsf_pkg::SPSF_MODE_I2C);
      // one wait state: pready rises in the second access cycle
      acc    = psel && penable && !pready;
      wr_en  = psel && penable && pready && pwrite;

      stat_d   = stat_q;
      ctrl_d   = ctrl_q;
      imask_d  = imask_q;
      rx_d     = rx_q;
      rxsh_d   = rxsh_q;
      txsh_d   = txsh_q;
      bits_d   = bits_q;
      tog_d    = tog_q;
      div_d    = div_q;
      dly_d    = dly_q;
      run_d    = run_q;
      sckl_d   = sckl_q;
      sdo_d    = sdo_out;
      addr_pend_d = addr_pend_q;
      ievt     = '0;

      // clock edges: generated in master mode, pin-sampled in slave mode
      edge_evt = 1'b0;
      lead_evt = 1'b0;
      if (master && run_q) begin
         if (div_q == 8'(SCK_HALF - 1)) begin
            div_d    = 8'h00;
            edge_evt = 1'b1;
            lead_evt = (sckl_q == ctrl_q.clk_idle_high);
            sckl_d   = ~sckl_q;
            tog_d    = 5'(tog_q + 5'h01);
            if (tog_q == spsf_pkg::SPI_TOGGLES - 5'h01) begin
               run_d = 1'b0;
            end
         end else begin
            div_d = 8'(div_q + 8'h01);
         end
      end else if (spi && !master) begin
         edge_evt = (sck_s != sck_prev_q);
         lead_evt = edge_evt && (sck_prev_q == ctrl_q.clk_idle_high);
      end
      trail_evt = edge_evt && !lead_evt;
      shift_evt = stat_q.edge_select ? trail_evt : lead_evt;
      samp_evt  = stat_q.edge_select ? lead_evt : trail_evt;

      // end-of-output sampling waits one more half period after mid-bit
      do_samp = 1'b0;
      if (master && stat_q.sample_phase_select) begin
         if (samp_evt) begin
            dly_d = 8'(SCK_HALF);
         end else if (dly_q != 8'h00) begin
            dly_d = 8'(dly_q - 8'h01);
            do_samp = (dly_q == 8'h01);
         end
      end else begin
         do_samp = samp_evt;
      end

      if (spi) begin
         if (shift_evt) begin
            sdo_d  = txsh_q[7];
            txsh_d = {txsh_q[6:0], 1'b0};
         end
         if (do_samp) begin
            rxsh_d = {rxsh_q[6:0], sd_s};
            bits_d = 4'(bits_q + 4'h1);
            if (bits_q == spsf_pkg::SPI_BITS - 4'h1) begin
               rx_d   = {rxsh_q[6:0], sd_s};
               bits_d = 4'h0;
               ievt[spsf_pkg::IRQ_BYTE] = 1'b1;
            end
         end
      end

      // I2C bus watch: sda moves while scl stays high
      start_evt = i2c && sck_s && sck_prev_q && sd_prev_q && !sd_s;
      stop_evt  = i2c && sck_s && sck_prev_q && !sd_prev_q && sd_s;
      if (start_evt) begin
         stat_d.start_seen = 1'b1;
         stat_d.stop_seen  = 1'b0;
         bits_d      = 4'h0;
         addr_pend_d = 1'b1;
         ievt[spsf_pkg::IRQ_START] = 1'b1;
      end else if (stop_evt) begin
         stat_d.stop_seen  = 1'b1;
         stat_d.start_seen = 1'b0;
         bits_d = 4'h0;
         ievt[spsf_pkg::IRQ_STOP] = 1'b1;
      end else if (i2c && sck_s && !sck_prev_q) begin
         bits_d = 4'(bits_q + 4'h1);
         if (bits_q < spsf_pkg::SPI_BITS) begin
            rxsh_d = {rxsh_q[6:0], sd_s};
         end
         // byte ends with the acknowledge clock
         if (bits_q == spsf_pkg::I2C_BITS - 4'h1) begin
            bits_d         = 4'h0;
            rx_d           = rxsh_q;
            stat_d.data_addr = !addr_pend_q;
            addr_pend_d    = 1'b0;
            ievt[spsf_pkg::IRQ_BYTE] = 1'b1;
         end
      end

      if (!en) begin
         stat_d.start_seen = 1'b0;
         stat_d.stop_seen  = 1'b0;
         run_d  = 1'b0;
         bits_d = 4'h0;
         dly_d  = 8'h00;
         sckl_d = ctrl_q.clk_idle_high;
      end

      // software writes; a set event wins over a write-one clear
      ist_d = ist_q | ievt;
      if (wr_en) begin
         unique case (paddr)
            spsf_pkg::ADDR_STATUS: begin
               stat_d.sample_phase_select = pwdata[7];
               stat_d.edge_select         = pwdata[6];
            end
            spsf_pkg::ADDR_CTRL: begin
               ctrl_d      = pwdata[7:0];
               ctrl_d.rsvd = 4'h0;
            end
            spsf_pkg::ADDR_IRQ_STAT: begin
               ist_d = (ist_q & ~pwdata[spsf_pkg::IRQ_W-1:0]) | ievt;
            end
            spsf_pkg::ADDR_IRQ_MASK: begin
               imask_d = pwdata[spsf_pkg::IRQ_W-1:0];
            end
            spsf_pkg::ADDR_DATA: begin
               if (spi) begin
                  // edge bit 1 puts bit 7 out at load; 0 waits for the leading edge
                  if (stat_q.edge_select) begin
                     sdo_d  = pwdata[7];
                     txsh_d = {pwdata[6:0], 1'b0};
                  end else begin
                     txsh_d = pwdata[7:0];
                  end
                  bits_d = 4'h0;
                  if (master) begin
                     run_d  = 1'b1;
                     div_d  = 8'h00;
                     tog_d  = 5'h00;
                     sckl_d = ctrl_q.clk_idle_high;
                  end
               end
            end
            default: begin
            end
         endcase
      end
      stat_d.low_bits = 3'h0;

      prdata_d  = prdata;
      pslverr_d = 1'b0;
      pready_d  = acc;
      if (acc) begin
         pslverr_d = !mapped(paddr);
         prdata_d  = 32'h0000_0000;
         unique case (paddr)
            spsf_pkg::ADDR_STATUS:   prdata_d[7:0] = stat_q;
            spsf_pkg::ADDR_CTRL:     prdata_d[7:0] = ctrl_q;
            spsf_pkg::ADDR_IRQ_STAT: prdata_d[spsf_pkg::IRQ_W-1:0] = ist_q;
            spsf_pkg::ADDR_IRQ_MASK: prdata_d[spsf_pkg::IRQ_W-1:0] = imask_q;
            spsf_pkg::ADDR_DATA:     prdata_d[7:0] = rx_q;
            default:                 prdata_d = 32'h0000_0000;
         endcase
      end
      irq_d = |(ist_d & imask_d);
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         stat_q      <= spsf_pkg::STATUS_RST;
         ctrl_q      <= spsf_pkg::CTRL_RST;
         ist_q       <= spsf_pkg::IRQ_RST;
         imask_q     <= spsf_pkg::IRQ_RST;
         rx_q        <= spsf_pkg::DATA_RST;
         rxsh_q      <= spsf_pkg::DATA_RST;
         txsh_q      <= spsf_pkg::DATA_RST;
         bits_q      <= 4'h0;
         tog_q       <= 5'h00;
         div_q       <= 8'h00;
         dly_q       <= 8'h00;
         run_q       <= 1'b0;
         sckl_q      <= 1'b0;
         addr_pend_q <= 1'b0;
         sck_prev_q  <= 1'b0;
         sd_prev_q   <= 1'b0;
         prdata      <= 32'h0000_0000;
         pready      <= 1'b0;
         pslverr     <= 1'b0;
         sck_out     <= 1'b0;
         sck_oe      <= 1'b0;
         sdo_out     <= 1'b0;
         sdo_oe      <= 1'b0;
         smbus_thresh_en <= 1'b0;
         irq         <= 1'b0;
      end else begin
         stat_q      <= stat_d;
         ctrl_q      <= ctrl_d;
         ist_q       <= ist_d;
         imask_q     <= imask_d;
         rx_q        <= rx_d;
         rxsh_q      <= rxsh_d;
         txsh_q      <= txsh_d;
         bits_q      <= bits_d;
         tog_q       <= tog_d;
         div_q       <= div_d;
         dly_q       <= dly_d;
         run_q       <= run_d;
         sckl_q      <= sckl_d;
         addr_pend_q <= addr_pend_d;
         sck_prev_q  <= sck_s;
         sd_prev_q   <= sd_s;
         prdata      <= prdata_d;
         pready      <= pready_d;
         pslverr     <= pslverr_d;
         sck_out     <= sckl_d;
         sck_oe      <= ctrl_d.port_enable_bit &&
                        (ctrl_d.mode == spsf_pkg::SPSF_MODE_SPI_MASTER);
         sdo_out     <= sdo_d;
         sdo_oe      <= spi;
         smbus_thresh_en <= i2c && stat_q.edge_select;
         irq         <= irq_d;
      end
   end
endmodule : spsf_top

// >>> bench/spsf_top_props.sv
// spsf_top_props: port-level checks of spsf_top.
// assumes one mclk domain; control words are shadowed from APB writes.
`timescale 1ns/10ps
module spsf_top_props (
   input wire logic        mclk,
   input wire logic        nrst,
   input wire logic [7:0]  paddr,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        sck_in,
   input wire logic        sd_in,
   input wire logic        sck_out,
   input wire logic        sck_oe,
   input wire logic        sdo_out,
   input wire logic        sdo_oe,
   input wire logic        smbus_thresh_en,
   input wire logic        irq
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!nrst);
   logic [7:0] ctl_q, ctl_d, st_q, st_d, msk_q, msk_d;
   logic [2:0] age_q, age_d;
   logic       wr, rd_st;
   assign wr    = psel && penable && pready && pwrite;
   assign rd_st = psel && penable && pready && !pwrite && paddr == spsf_pkg::ADDR_STATUS;
   always_comb begin
      ctl_d = (wr && paddr == spsf_pkg::ADDR_CTRL) ? pwdata[7:0] : ctl_q;
      st_d  = (wr && paddr == spsf_pkg::ADDR_STATUS) ? pwdata[7:0] : st_q;
      msk_d = (wr && paddr == spsf_pkg::ADDR_IRQ_MASK) ? pwdata[7:0] : msk_q;
      // saturating age: outputs are judged only once a write has settled
      age_d = wr ? 3'h0 : age_q + {2'h0, age_q != 3'h7};
   end
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         {ctl_q, st_q, msk_q, age_q} <= 27'h000_0000;
      end else begin
         {ctl_q, st_q, msk_q, age_q} <= {ctl_d, st_d, msk_d, age_d};
      end
   end
   apb_pulse_a: assert property (pready |=> !pready)
      else $error("pready held for more than one cycle");
   apb_wait_a: assert property (psel && !penable ##1 psel && penable |-> !pready ##1 pready)
      else $error("access phase did not last two cycles");
   apb_err_a: assert property (pready |->
      pslverr == (paddr > spsf_pkg::ADDR_DATA || paddr[1:0] != 2'b00))
      else $error("pslverr does not match the address map");
   thresh_follow_a: assert property (age_q == 3'h7 |->
      smbus_thresh_en == (ctl_q[2:0] == 3'b101 && st_q[6])) else $error("threshold pin wrong");
   oe_mode_a: assert property (age_q == 3'h7 |-> sck_oe == (ctl_q[2:0] == 3'b001))
      else $error("clock enable does not follow master mode");
   flags_off_a: assert property (rd_st && !ctl_q[0] |-> prdata[4:3] == 2'b00)
      else $error("condition flags set while port disabled");
   flags_excl_a: assert property (rd_st |-> !(prdata[4] && prdata[3]))
      else $error("start and stop flags both set");
   sdo_lead_a: assert property (sck_oe && !st_q[6] && $changed(sdo_out) |->
      $changed(sck_out) && sck_out != ctl_q[3]) else $error("data moved off leading edge");
   irq_mask_a: assert property (age_q == 3'h7 && msk_q[2:0] == 3'h0 |-> !irq)
      else $error("interrupt raised while fully masked");
   cover property (pready && pslverr);
   cover property (rd_st && prdata[4]);
   cover property ($rose(irq));
endmodule : spsf_top_props
bind spsf_top spsf_top_props spsf_top_props_i (.*);

// >>> bench/spsf_peer.sv
// spsf_peer: bus partner on the pins, an I2C master or an SPI slave.
// assumes pull-ups on both lines; the SPI clock idles low.
`timescale 1ns/10ps
module spsf_peer (
   input  wire logic sck_out,
   output logic      sck_in,
   output logic      sd_in
);
   logic [7:0] tx_q;
   logic       spi_q, trail_q, late_q;
   initial {sck_in, sd_in, tx_q, spi_q, trail_q, late_q} = 13'h1800;
   // shifts on the leading edge, or on the trailing one when asked
   always @(sck_out) begin
      if (spi_q && sck_out === !trail_q) begin
         // late bit: wrong until past mid-bit, so only end sampling sees it
         sd_in = late_q ? ~tx_q[7] : tx_q[7];
         if (late_q) sd_in <= #25 tx_q[7];
         tx_q  = {tx_q[6:0], 1'b0};
      end
   end
   task automatic load(input logic [7:0] b, input logic t, input logic l);
      trail_q = t;
      late_q  = l;
      // line not yet valid for a leading-edge shift: inverse so a stale bit never passes
      sd_in   = t ? b[7] : ~b[7];
      tx_q    = t ? {b[6:0], 1'b0} : b;
      spi_q   = 1'b1;
   endtask : load
   task automatic bit_out(input logic b);
      sd_in = b;
      #20 sck_in = 1'b1;
      #40 sck_in = 1'b0;
      #20;
   endtask : bit_out
   task automatic start;
      sd_in = 1'b1;
      #20 sck_in = 1'b1;
      #20 sd_in = 1'b0;
      #20 sck_in = 1'b0;
      #40;
   endtask : start
   task automatic stop;
      sd_in = 1'b0;
      #20 sck_in = 1'b1;
      #20 sd_in = 1'b1;
      #60;
   endtask : stop
   // eight bits msb first, then the released acknowledge slot
   task automatic send(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) bit_out(b[i]);
      bit_out(1'b1);
      #40;
   endtask : send
endmodule : spsf_peer

// >>> bench/spsf_top_tb.sv
// spsf_top_tb: register, I2C watcher and SPI master scenarios of spsf_top.
// assumes spsf_peer plays the bus partner on sck_in and sd_in.
`timescale 1ns/10ps
module spsf_top_tb;
   logic        mclk, nrst, psel, penable, pwrite, pready, pslverr, err_v, cap_pos;
   logic        sck_in, sd_in, sck_out, sck_oe, sdo_out, sdo_oe, smbus_thresh_en, irq;
   logic [7:0]  paddr, cap;
   logic [31:0] pwdata, prdata, rd_v;
   int          bad_count, comparisons, n;
   always #5 mclk = ~mclk;
   spsf_top spsf_top_i (.*);
   spsf_peer spsf_peer_i (.sck_out(sck_out), .sck_in(sck_in), .sd_in(sd_in));
   // wire capture on the edge opposite to the shift edge
   always @(sck_out) if (sck_out === cap_pos) cap = {cap[6:0], sdo_out};
   task automatic finish_test;
      $display("compares %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : finish_test
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
      int k;
      @(posedge mclk);
      {psel, penable, pwrite, paddr} <= {2'b10, w, a};
      pwdata <= {24'h00_0000, d};
      @(posedge mclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge mclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      {rd_v, err_v} = {prdata, pslverr};
      {psel, penable} <= 2'b00;
      if (k == 20) begin
         bad_count++;
         finish_test();
      end
   endtask : xfer
   task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m = 8'hff);
      xfer(1'b0, a, 8'h00);
      chk(rd_v & {24'h00_0000, m}, {24'h00_0000, e});
   endtask : rd
   // pins are read after the wait, not when the task is called
   task automatic pin(input int sel, input logic exp);
      logic [3:0] v;
      repeat (3) @(posedge mclk);
      v = {sdo_oe, sck_oe, irq, smbus_thresh_en};
      chk(v[sel], exp);
   endtask : pin
   initial begin
      {mclk, nrst, psel, penable, pwrite, cap_pos, paddr, cap} = 22'h00_0000;
      {pwdata, bad_count, comparisons} = '0;
      repeat (4) @(posedge mclk);
      nrst <= 1'b1;
      for (int a = 0; a < 20; a += 4) rd(a[7:0], 8'h00);
      rd(8'h14, 8'h00);
      chk(err_v, 1'h1);
      xfer(1'b1, spsf_pkg::ADDR_STATUS, 8'hff);
      rd(spsf_pkg::ADDR_STATUS, 8'hc0);
      for (int i = 0; i < 3; i++) begin
         xfer(1'b1, spsf_pkg::ADDR_CTRL, i == 2 ? 8'h01 : 8'h05);
         xfer(1'b1, spsf_pkg::ADDR_STATUS, i == 1 ? 8'h00 : 8'h40);
         pin(0, i == 0);
      end
      xfer(1'b1, spsf_pkg::ADDR_CTRL, 8'h05);
      xfer(1'b1, spsf_pkg::ADDR_STATUS, 8'h00);
      spsf_peer_i.start();
      rd(spsf_pkg::ADDR_STATUS, 8'h08);
      rd(spsf_pkg::ADDR_IRQ_STAT, 8'h01);
      chk(irq, 1'h0);
      xfer(1'b1, spsf_pkg::ADDR_IRQ_MASK, 8'h07);
      pin(1, 1'h1);
      spsf_peer_i.send(8'ha5);
      rd(spsf_pkg::ADDR_STATUS, 8'h08);
      rd(spsf_pkg::ADDR_DATA, 8'ha5);
      spsf_peer_i.send(8'h3c);
      rd(spsf_pkg::ADDR_STATUS, 8'h28);
      rd(spsf_pkg::ADDR_DATA, 8'h3c);
      spsf_peer_i.stop();
      rd(spsf_pkg::ADDR_STATUS, 8'h30);
      rd(spsf_pkg::ADDR_IRQ_STAT, 8'h07);
      xfer(1'b1, spsf_pkg::ADDR_IRQ_STAT, 8'h07);
      rd(spsf_pkg::ADDR_IRQ_STAT, 8'h00);
      pin(1, 1'h0);
      spsf_peer_i.start();
      rd(spsf_pkg::ADDR_STATUS, 8'h08, 8'h18);
      xfer(1'b1, spsf_pkg::ADDR_CTRL, 8'h04);
      rd(spsf_pkg::ADDR_STATUS, 8'h00, 8'h18);
      xfer(1'b1, spsf_pkg::ADDR_CTRL, 8'h01);
      xfer(1'b1, spsf_pkg::ADDR_IRQ_MASK, 8'h04);
      for (int i = 0; i < 4; i++) begin
         xfer(1'b1, spsf_pkg::ADDR_STATUS, {i[1:0], 6'h00});
         cap_pos = i[0];
         spsf_peer_i.load(8'h96 ^ i[7:0], i[0], i[1]);
         xfer(1'b1, spsf_pkg::ADDR_DATA, 8'h5a + i[7:0]);
         n = 0;
         do begin
            xfer(1'b0, spsf_pkg::ADDR_IRQ_STAT, 8'h00);
            n++;
         end while (rd_v[2] !== 1'b1 && n < 60);
         if (n == 60) begin
            bad_count++;
            finish_test();
         end
         chk(irq, 1'h1);
         chk(cap, 8'h5a + i[7:0]);
         rd(spsf_pkg::ADDR_DATA, 8'h96 ^ i[7:0]);
         xfer(1'b1, spsf_pkg::ADDR_IRQ_STAT, 8'h04);
      end
      // slave mode: peer drives the clock, sampled on the leading edge
      xfer(1'b1, spsf_pkg::ADDR_CTRL, 8'h03);
      xfer(1'b1, spsf_pkg::ADDR_STATUS, 8'h40);
      pin(3, 1'h1);
      chk(sck_oe, 1'h0);
      spsf_peer_i.send(8'hc3);
      rd(spsf_pkg::ADDR_DATA, 8'hc3);
      rd(spsf_pkg::ADDR_IRQ_STAT, 8'h04, 8'h04);
      chk(irq, 1'h1);
      finish_test();
   end
endmodule : spsf_top_tb
